// File: rtl/pll_cfg_defines.svh
// offsets, field values, reset values and timing counts of the clock path control
// assumes inclusion by the package, the design files and the testbench
`ifndef PLL_CFG_DEFINES_SVH
`define PLL_CFG_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_CTRL 12'h010
`define IDX_BACKLASH 12'h017
`define IDX_CAL 12'h018
`define IDX_PUMP_CUR 12'h020
`define IDX_STATUS 12'h021
`define IDX_PREDIV 12'h1E0
`define IDX_SOURCE 12'h1E1
`define IDX_UPDATE 12'h232
`define BYTE_ADDR(idx) ((idx) * 4)

// field values
`define PWR_NORMAL 2'h0
`define PWR_DOWN 2'h1
`define PUMP_HIZ 3'h0
`define PUMP_FORCE_UP 3'h1
`define PUMP_FORCE_DOWN 3'h2
`define PUMP_NORMAL 3'h3
`define PREDIV_DIV4 3'h2
`define PREDIV_DIV6 3'h4
`define UPDATE_CMD 8'h01

// reset values
`define RST_CTRL 8'h01
`define RST_PREDIV 3'h2

// timing
`define CLK_PERIOD_NS 5
`define CAL_TIME_NS 2000
`define CAL_CYCLES ((`CAL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: rtl/pll_cfg_pkg.sv
// types of the clock path control
// assumes the defines header sits beside it
package pll_cfg_pkg;
    `include "pll_cfg_defines.svh"

    // one full set of clock path settings, staged or active
    typedef struct packed {
        logic [1:0] power;
        logic [2:0] pump_mode;
        logic polarity;
        logic [1:0] backlash;
        logic [2:0] pump_current;
        logic cal;
        logic [2:0] prediv;
        logic bypass;
        logic source;
    } cfg_type;

    // charge pump drive
    typedef struct packed {
        logic up;
        logic down;
        logic hiz;
    } pump_type;

    typedef enum logic {CAL_IDLE, CAL_RUN} cal_state_type;
endpackage

// File: rtl/pll_clock_path_config.sv
// clock path and pll control registers behind an apb slave
// assumes an apb3 master on pclk and edge pins from the r and n counters
//
// How it works
// - power field 00b runs the pll, 01b powers it down
// - pre-divider field picks divide by 2, 3, 4, 5 or 6
// - bypass bit 0 feeds distribution from pre-divider, 1 feeds source directly
// - source bit 1 picks internal oscillator, 0 picks external clock input
// - polarity bit 0 positive, 1 negative
// - polarity only matters with the external oscillator
// - settings take effect only after 0x01 written to the update register
// - calibration starts when an update raises the calibration bit from 0 to 1
// - pll register range holds polarity, pump and detector settings
// - detector compares r and n counter outputs
// - two-bit field sets antibacklash pulse width
// - detector commands pump up or pump down
// - pump mode: high impedance, normal, forced up, forced down
// - pump current has eight programmable steps
// - pre-divider code 010b divides by 4 and is the reset value
// - after reset pll off, pre-divider in path, external source
`include "pll_cfg_defines.svh"

module pll_clock_path_config
    import pll_cfg_pkg::*;
#(
    parameter int CAL_LEN = `CAL_CYCLES
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // counter edges from outside
    input wire logic ref_edge_in,
    input wire logic fb_edge_in,
    // clock path control
    output logic pll_power_down,
    output logic source_internal,
    output logic prediv_bypass,
    output logic [2:0] prediv_ratio,
    output logic dist_feed,
    output logic [2:0] pump_current_setting,
    output pll_cfg_pkg::pump_type pump,
    // calibration
    output logic cal_start,
    output logic cal_busy
);
    import pll_cfg_pkg::*;

    cfg_type staged;
    cfg_type active;
    logic upd_pending;
    logic [11:0] idx;
    logic wr_en;
    logic mapped;
    logic [7:0] rd_val;
    logic [1:0] ref_sync;
    logic [1:0] fb_sync;
    logic pfd_up;
    logic pfd_down;
    logic pol_swap;
    logic [2:0] div_cnt;
    logic div_tick;
    cal_state_type cal_state;
    logic [$clog2(CAL_LEN + 1) - 1:0] cal_cnt;

    //--------------------------------------------------------------
    // apb decode
    //--------------------------------------------------------------

    // word index from byte address
    assign idx = {2'h0, paddr[11:2]};
    assign wr_en = psel && penable && pwrite;
    assign pready = 1'b1;

    // register read mux and map check
    always_comb
    begin
        mapped = 1'b1;
        rd_val = 8'h00;
        case (idx)
            `IDX_CTRL: rd_val = {staged.polarity, staged.pump_mode, 2'h0, staged.power};
            `IDX_BACKLASH: rd_val = {6'h00, staged.backlash};
            `IDX_CAL: rd_val = {7'h00, staged.cal};
            `IDX_PUMP_CUR: rd_val = {5'h00, staged.pump_current};
            `IDX_STATUS: rd_val = {4'h0, pump.hiz, pfd_down, pfd_up, cal_busy};
            `IDX_PREDIV: rd_val = {5'h00, staged.prediv};
            `IDX_SOURCE: rd_val = {6'h00, staged.source, staged.bypass};
            `IDX_UPDATE: rd_val = {7'h00, upd_pending};
            default: mapped = 1'b0;
        endcase
    end

    // read data and error latched in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata <= {24'h00_0000, rd_val};
            pslverr <= !mapped;
        end
    end

    //--------------------------------------------------------------
    // staged and active settings
    //--------------------------------------------------------------

    // software writes land in the staged copy
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            staged <= '0;
            staged.power <= `PWR_DOWN;
            staged.prediv <= `RST_PREDIV;
        end
        else if (wr_en)
        begin
            case (idx)
                `IDX_CTRL:
                begin
                    staged.power <= pwdata[1:0];
                    staged.pump_mode <= pwdata[6:4];
                    staged.polarity <= pwdata[7];
                end
                `IDX_BACKLASH: staged.backlash <= pwdata[1:0];
                `IDX_CAL: staged.cal <= pwdata[0];
                `IDX_PUMP_CUR: staged.pump_current <= pwdata[2:0];
                `IDX_PREDIV: staged.prediv <= pwdata[2:0];
                `IDX_SOURCE:
                begin
                    staged.bypass <= pwdata[0];
                    staged.source <= pwdata[1];
                end
                default: staged <= staged;
            endcase
        end
    end

    // update request, cleared by the transfer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            upd_pending <= 1'b0;
        end
        else if (wr_en && idx == `IDX_UPDATE && pwdata[7:0] == `UPDATE_CMD)
        begin
            upd_pending <= 1'b1;
        end
        else
        begin
            upd_pending <= 1'b0;
        end
    end

    // staged copy moves to active only on update
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            active <= '0;
            active.power <= `PWR_DOWN;
            active.prediv <= `RST_PREDIV;
        end
        else if (upd_pending)
        begin
            active <= staged;
        end
    end

    //--------------------------------------------------------------
    // clock path
    //--------------------------------------------------------------

    assign pll_power_down = (active.power != `PWR_NORMAL);
    assign source_internal = active.source;
    assign prediv_bypass = active.bypass;
    assign pump_current_setting = active.pump_current;

    // code to ratio, codes above divide by 6 saturate
    always_comb
    begin
        if (active.prediv > `PREDIV_DIV6)
        begin
            prediv_ratio = 3'h6;
        end
        else
        begin
            prediv_ratio = active.prediv + 3'h2;
        end
    end

    // pre-divider tick counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt <= 3'h0;
        end
        else if (div_cnt >= prediv_ratio - 3'h1)
        begin
            div_cnt <= 3'h0;
        end
        else
        begin
            div_cnt <= div_cnt + 3'h1;
        end
    end

    assign div_tick = (div_cnt == 3'h0);
    // distribution fed from pre-divider or source directly
    assign dist_feed = active.bypass ? 1'b1 : div_tick;

    //--------------------------------------------------------------
    // phase detector and charge pump
    //--------------------------------------------------------------

    // two-flop synchronisers, edge history lives inside the detector
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_sync <= 2'h0;
            fb_sync <= 2'h0;
        end
        else
        begin
            ref_sync <= {ref_sync[0], ref_edge_in};
            fb_sync <= {fb_sync[0], fb_edge_in};
        end
    end

    pll_phase_detector u_pfd (
        .pclk(pclk),
        .presetn(presetn),
        .ref_level(ref_sync[1]),
        .fb_level(fb_sync[1]),
        .backlash(active.backlash),
        .up(pfd_up),
        .down(pfd_down)
    );

    // negative polarity swaps pump direction, external oscillator only
    assign pol_swap = active.polarity && !active.source;

    // pump drive from mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pump <= '{up: 1'b0, down: 1'b0, hiz: 1'b1};
        end
        else
        begin
            case (active.pump_mode)
                `PUMP_NORMAL: pump <= '{up: pol_swap ? pfd_down : pfd_up,
                    down: pol_swap ? pfd_up : pfd_down, hiz: 1'b0};
                `PUMP_FORCE_UP: pump <= '{up: 1'b1, down: 1'b0, hiz: 1'b0};
                `PUMP_FORCE_DOWN: pump <= '{up: 1'b0, down: 1'b1, hiz: 1'b0};
                default: pump <= '{up: 1'b0, down: 1'b0, hiz: 1'b1};
            endcase
        end
    end

    //--------------------------------------------------------------
    // oscillator calibration
    //--------------------------------------------------------------

    // start on update that raises the calibration bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cal_start <= 1'b0;
        end
        else
        begin
            cal_start <= upd_pending && staged.cal && !active.cal;
        end
    end

    // calibration run timer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cal_state <= CAL_IDLE;
            cal_cnt <= '0;
        end
        else
        begin
            case (cal_state)
                CAL_IDLE:
                begin
                    if (cal_start)
                    begin
                        cal_state <= CAL_RUN;
                        cal_cnt <= '0;
                    end
                end
                CAL_RUN:
                begin
                    if (cal_cnt == ($bits(cal_cnt))'(CAL_LEN - 1))
                    begin
                        cal_state <= CAL_IDLE;
                    end
                    else
                    begin
                        cal_cnt <= cal_cnt + 1'b1;
                    end
                end
                default: cal_state <= CAL_IDLE;
            endcase
        end
    end

    assign cal_busy = (cal_state == CAL_RUN);

    //--------------------------------------------------------------
    // checks
    //--------------------------------------------------------------

    property p_upd_clear;
        @(posedge pclk) disable iff (!presetn)
        upd_pending |=> !upd_pending;
    endproperty
    a_upd_clear: assert property (p_upd_clear)
        else $error("update bit did not clear");

    property p_transfer;
        @(posedge pclk) disable iff (!presetn)
        upd_pending |=> (active == $past(staged));
    endproperty
    a_transfer: assert property (p_transfer)
        else $error("staged settings not transferred");

    property p_hold_active;
        @(posedge pclk) disable iff (!presetn)
        !upd_pending |=> $stable(active);
    endproperty
    a_hold_active: assert property (p_hold_active)
        else $error("active settings changed without update");

    property p_power;
        @(posedge pclk) disable iff (!presetn)
        (upd_pending && staged.power == `PWR_DOWN) |=> pll_power_down;
    endproperty
    a_power: assert property (p_power)
        else $error("pll not powered down");

    property p_cal_run;
        @(posedge pclk) disable iff (!presetn)
        (upd_pending && staged.cal && !active.cal) |=> ##1 cal_busy [*8];
    endproperty
    a_cal_run: assert property (p_cal_run)
        else $error("calibration did not start");

    property p_internal_pol;
        @(posedge pclk) disable iff (!presetn)
        (active.pump_mode == `PUMP_NORMAL && active.source && pfd_up) |=> pump.up;
    endproperty
    a_internal_pol: assert property (p_internal_pol)
        else $error("polarity applied with internal oscillator");

    property p_hiz;
        @(posedge pclk) disable iff (!presetn)
        (active.pump_mode == `PUMP_HIZ) |=> (pump.hiz && !pump.up && !pump.down);
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("pump not in high impedance");

    property p_div4;
        @(posedge pclk) disable iff (!presetn)
        (active.prediv == `PREDIV_DIV4 && !active.bypass && div_tick) |=>
            (active.prediv != `PREDIV_DIV4 || active.bypass || !dist_feed)
            ##1 (active.prediv != `PREDIV_DIV4 || active.bypass || !dist_feed)
            ##1 (active.prediv != `PREDIV_DIV4 || active.bypass || !dist_feed);
    endproperty
    a_div4: assert property (p_div4)
        else $error("divide by 4 spacing wrong");
endmodule

// File: rtl/pll_phase_detector.sv
// phase frequency detector with antibacklash hold
// assumes both edge levels are already synchronised to pclk
module pll_phase_detector
    import pll_cfg_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // compared inputs
    input wire logic ref_level,
    input wire logic fb_level,
    input wire logic [1:0] backlash,
    // pump requests
    output logic up,
    output logic down
);
    import pll_cfg_pkg::*;

    logic ref_last;
    logic fb_last;
    logic [1:0] hold;

    // edge history
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_last <= 1'b0;
            fb_last <= 1'b0;
        end
        else
        begin
            ref_last <= ref_level;
            fb_last <= fb_level;
        end
    end

    // up on reference edge, down on feedback edge, both cleared after hold
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            up <= 1'b0;
            down <= 1'b0;
            hold <= 2'h0;
        end
        else if (up && down)
        begin
            if (hold == backlash)
            begin
                up <= 1'b0;
                down <= 1'b0;
                hold <= 2'h0;
            end
            else
            begin
                hold <= hold + 2'h1;
            end
        end
        else
        begin
            if (ref_level && !ref_last)
            begin
                up <= 1'b1;
            end
            if (fb_level && !fb_last)
            begin
                down <= 1'b1;
            end
        end
    end

    // both requests end within the antibacklash hold
    property p_backlash_end;
        @(posedge pclk) disable iff (!presetn)
        (up && down) |-> ##[1:4] (!up && !down);
    endproperty
    a_backlash_end: assert property (p_backlash_end)
        else $error("antibacklash hold did not end");
endmodule

// File: verif/testbench.sv
// self-checking bench for the clock path control block
// assumes the design package, defines header and design modules are compiled first
`include "pll_cfg_defines.svh"

module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import pll_cfg_pkg::*;

    // ----------------------------------------
    // signals and design under test
    // ----------------------------------------
    localparam int CAL_LEN = 10; // short calibration for simulation
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic ref_edge_in = 1'b0;
    logic fb_edge_in = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pll_power_down;
    logic source_internal;
    logic prediv_bypass;
    logic [2:0] prediv_ratio;
    logic dist_feed;
    logic [2:0] pump_current_setting;
    pump_type pump;
    logic cal_start;
    logic cal_busy;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_start = 0;
    int n_busy = 0;
    logic [2:0] pm_exp [4] = '{3'b001, 3'b100, 3'b010, 3'b000};

    pll_clock_path_config #(.CAL_LEN(CAL_LEN)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ref_edge_in(ref_edge_in), .fb_edge_in(fb_edge_in),
        .pll_power_down(pll_power_down), .source_internal(source_internal),
        .prediv_bypass(prediv_bypass), .prediv_ratio(prediv_ratio), .dist_feed(dist_feed),
        .pump_current_setting(pump_current_setting), .pump(pump),
        .cal_start(cal_start), .cal_busy(cal_busy)
    );

    // clock generator
    always #2.5 pclk = ~pclk;

    // calibration pulse and busy counters
    always @(negedge pclk)
    begin
        if (cal_start === 1'b1) n_start++;
        if (cal_busy === 1'b1) n_busy++;
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx[9:0], 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // transfer staged settings and let outputs settle
    task automatic upd;
        apb(1'b1, `IDX_UPDATE, `UPDATE_CMD);
        repeat (3) @(posedge pclk);
    endtask

    // lead edge on reference pin, then feedback, measuring the overlap
    task automatic edge_run(input logic [7:0] ctrl, input logic [7:0] src,
                            input logic [2:0] lead, input int bl);
        int both;
        both = 0;
        apb(1'b1, `IDX_CTRL, ctrl);
        apb(1'b1, `IDX_SOURCE, src);
        apb(1'b1, `IDX_BACKLASH, bl[7:0]);
        upd();
        ref_edge_in <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("pump_lead", {29'h0, lead}, {29'h0, pump});
        fb_edge_in <= 1'b1;
        repeat (12)
        begin
            @(negedge pclk);
            if (pump.up === 1'b1 && pump.down === 1'b1) both++;
        end
        chk("backlash", bl + 1, both);
        @(posedge pclk);
        ref_edge_in <= 1'b0;
        fb_edge_in <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask

    task automatic finish_test;
        if (n_mismatch == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        finish_test();
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial
    begin
        int ticks;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset state
        chk("power_down", 1, pll_power_down);
        chk("source_internal", 0, source_internal);
        chk("bypass", 0, prediv_bypass);
        chk("ratio", 4, prediv_ratio);
        chk("pump", 32'h1, {29'h0, pump});
        apb(1'b0, `IDX_PREDIV, 8'h00);
        chk("prediv_reg", 32'h2, rd);
        // staged values wait for the update
        apb(1'b1, `IDX_CTRL, 8'h30);
        apb(1'b1, `IDX_SOURCE, 8'h01);
        repeat (3) @(posedge pclk);
        chk("power_down_staged", 1, pll_power_down);
        chk("bypass_staged", 0, prediv_bypass);
        upd();
        chk("power_down", 0, pll_power_down);
        chk("source_internal", 0, source_internal);
        chk("bypass", 1, prediv_bypass);
        chk("dist_feed", 1, dist_feed);
        apb(1'b0, `IDX_UPDATE, 8'h00);
        chk("update_reg", 0, rd);
        apb(1'b0, `IDX_CTRL, 8'h00);
        chk("ctrl_reg", 32'h30, rd);
        // wrong update value is ignored
        apb(1'b1, `IDX_CTRL, 8'h01);
        apb(1'b1, `IDX_UPDATE, 8'h02);
        repeat (3) @(posedge pclk);
        chk("power_down_bad_upd", 0, pll_power_down);
        upd();
        chk("power_down", 1, pll_power_down);
        // unmapped place
        apb(1'b1, 12'h100, 8'h55);
        chk("slverr_wr", 1, err);
        apb(1'b0, 12'h100, 8'h00);
        chk("slverr_rd", 1, err);
        chk("unmapped_rd", 0, rd);
        // every divide ratio through the pre-divider
        apb(1'b1, `IDX_SOURCE, 8'h00);
        for (int c = 0; c < 5; c++)
        begin
            apb(1'b1, `IDX_PREDIV, c[7:0]);
            upd();
            chk("ratio", c + 2, prediv_ratio);
            ticks = 0;
            repeat (60)
            begin
                @(negedge pclk);
                if (dist_feed === 1'b1) ticks++;
            end
            chk("feed_ticks", 60 / (c + 2), ticks);
            @(posedge pclk);
        end
        // pump current steps
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, `IDX_PUMP_CUR, i[7:0]);
            upd();
            chk("pump_current", i, pump_current_setting);
        end
        // pump modes
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, `IDX_CTRL, {1'b0, i[2:0], 4'h0});
            upd();
            chk("pump_mode", {29'h0, pm_exp[i]}, {29'h0, pump});
        end
        // detector with both polarities and sources
        edge_run(8'h30, 8'h00, 3'b100, 0);
        edge_run(8'hB0, 8'h00, 3'b010, 2);
        edge_run(8'hB0, 8'h02, 3'b100, 3);
        // calibration start, repeat and restart
        chk("source_internal", 1, source_internal);
        chk("bypass", 0, prediv_bypass);
        apb(1'b1, `IDX_CAL, 8'h01);
        upd();
        repeat (20) @(posedge pclk);
        chk("cal_starts", 1, n_start);
        chk("cal_busy", CAL_LEN, n_busy);
        upd();
        repeat (20) @(posedge pclk);
        chk("cal_no_restart", 1, n_start);
        apb(1'b1, `IDX_CAL, 8'h00);
        upd();
        apb(1'b1, `IDX_CAL, 8'h01);
        upd();
        repeat (20) @(posedge pclk);
        chk("cal_starts", 2, n_start);
        chk("cal_busy", 2 * CAL_LEN, n_busy);
        finish_test();
    end
endmodule
